// ===== swd_regs.vh
`ifndef SWD_REGS_VH
`define SWD_REGS_VH
// Notes on behaviour
// R1 - while enabled, counter decrements once per tick from the start value
// R2 - at zero, flag malfunction and perform every selected expiry action
// R3 - start value 1 to ffff-1; each count is ten microseconds
// R4 - configuration enable bit: 0 disables, 1 enables; disabled after reset
// R5 - mask bit 0 halts main processor, bit 1 halts coprocessor on expiry
// R6 - mask bit 3 forces general outputs and digital io lines low on expiry
// R7 - mask bit 2 and enabled: output high while counting, low at zero
// R8 - mask bit 2 clear or disabled: output follows standby level
// R9 - reload restores start value and keeps the counter enabled
// R10 - reload while disabled has no effect
// R11 - software reloads within every counting period to avoid expiry
// R12 - standby level 0 gives low, 1 gives high on watchdog output
// R13 - standby level applies only when disabled or output not driven by counter
// R14 - after power-up the watchdog output is low
// R15 - status bit 0 reads one when enabled, zero when disabled
// R16 - status bit 1 reads one after reaching zero, zero while counting
// R17 - status bit 1 is meaningless while disabled; software ignores it
// R18 - status bits above bit 1 have no function; read as zero
// R19 - after expiry counter holds zero, flag set, until reconfigured; config clears flag
// R20 - tick derived from system clock by prescaler; configuration restarts it

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define SWD_ADDR_W         4
`define SWD_OFS_CONFIG     4'h0
`define SWD_OFS_START      4'h1
`define SWD_OFS_RELOAD     4'h2
`define SWD_OFS_STANDBY    4'h3
`define SWD_OFS_STATUS     4'h4
`define SWD_OFS_COUNT      4'h5

// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define SWD_CFG_EN_BIT     0
`define SWD_CFG_MODE_LSB   4
`define SWD_CFG_MODE_MSB   7
`define SWD_MODE_HALT_MAIN 0
`define SWD_MODE_HALT_COP  1
`define SWD_MODE_PIN       2
`define SWD_MODE_FORCE_LOW 3
`define SWD_ST_EN_BIT      0
`define SWD_ST_FAULT_BIT   1
`define SWD_START_MIN      16'h0001
`define SWD_START_MAX      16'hfffe

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SWD_CLK_HZ         25000000
`define SWD_TICK_NS        10000
`define SWD_CLK_NS         40
`define SWD_TICK_CYC       (`SWD_TICK_NS / `SWD_CLK_NS)
`endif

// ===== swd_prescaler.v
`timescale 1ns/100ps
`include "swd_regs.vh"
module swd_prescaler #(
   parameter DIV = `SWD_TICK_CYC
) (
   input  wire ref_clk_i,
   input  wire rst_n_i,
   input  wire restart_i,
   output reg  tick_o
);
   reg [15:0] cnt_reg;

   // ------------------------------------------------------------
   // ten microsecond tick
   // ------------------------------------------------------------
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= 16'h0000;
         tick_o  <= 1'b0;
      end else if (restart_i) begin // R20
         cnt_reg <= 16'h0000;
         tick_o  <= 1'b0;
      end else if (cnt_reg == DIV[15:0] - 16'h0001) begin // R20
         cnt_reg <= 16'h0000;
         tick_o  <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
         tick_o  <= 1'b0;
      end
   end
endmodule

// ===== swd_downcount.v
`timescale 1ns/100ps
`include "swd_regs.vh"
module swd_downcount #(
   parameter W = 16
) (
   input  wire         ref_clk_i,
   input  wire         rst_n_i,
   input  wire         load_i,
   input  wire [W-1:0] load_val_i,
   input  wire         run_i,
   input  wire         tick_i,
   output reg  [W-1:0] count_o,
   output wire         zero_o
);
   assign zero_o = (count_o == {W{1'b0}});

   // ------------------------------------------------------------
   // counter, holds at zero
   // ------------------------------------------------------------
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_o <= {W{1'b0}};
      end else if (load_i) begin // R9
         count_o <= load_val_i;
      end else if (run_i && tick_i && !zero_o) begin // R1 R19
         count_o <= count_o - {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule

// ===== swd_supervisor.v
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`include "swd_regs.vh"
module swd_supervisor #(
   parameter TICK_CYC = `SWD_TICK_CYC,
   parameter N_GEN    = 8,
   parameter N_DIO    = 33
) (
   input  wire                   ref_clk_i,
   input  wire                   reset_n_i,
   input  wire [`SWD_ADDR_W-1:0] addr_i,
   input  wire [31:0]            wdata_i,
   input  wire                   wr_i,
   input  wire                   rd_i,
   output reg  [31:0]            rdata_o,
   output reg                    halt_main_o,
   output reg                    halt_cop_o,
   output reg                    force_low_o,
   output reg  [N_GEN-1:0]       gen_out_en_o,
   output reg  [N_DIO-1:0]       dio_out_en_o,
   output reg                    wd_out_o
);
   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   reg rst_s1_reg;
   reg rst_n;
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_s1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n      <= rst_s1_reg;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg        enable_reg;
   reg [3:0]  mode_reg;
   reg [15:0] start_reg;
   reg        standby_reg;
   reg        fault_reg;
   reg        cfg_pulse_reg;
   reg        load_reg;

   wire        tick;
   wire [15:0] count;
   wire        zero;

   wire wr_cfg    = wr_i && (addr_i == `SWD_OFS_CONFIG);
   wire wr_start  = wr_i && (addr_i == `SWD_OFS_START);
   wire wr_reload = wr_i && (addr_i == `SWD_OFS_RELOAD);
   wire wr_stby   = wr_i && (addr_i == `SWD_OFS_STANDBY);

   // clamp start value into its legal range
   function [15:0] clamp_start;
      input [15:0] v;
      begin
         if (v < `SWD_START_MIN)
            clamp_start = `SWD_START_MIN;
         else if (v > `SWD_START_MAX)
            clamp_start = `SWD_START_MAX;
         else
            clamp_start = v;
      end
   endfunction

   always @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         enable_reg    <= 1'b0; // R4
         mode_reg      <= 4'h0;
         start_reg     <= `SWD_START_MAX;
         standby_reg   <= 1'b0; // R14
         cfg_pulse_reg <= 1'b0;
         load_reg      <= 1'b0;
      end else begin
         cfg_pulse_reg <= wr_cfg;
         load_reg      <= 1'b0;
         if (wr_cfg) begin
            enable_reg <= wdata_i[`SWD_CFG_EN_BIT]; // R4
            mode_reg   <= wdata_i[`SWD_CFG_MODE_MSB:`SWD_CFG_MODE_LSB];
            load_reg   <= 1'b1;
         end
         if (wr_start)
            start_reg <= clamp_start(wdata_i[15:0]); // R3
         // after expiry the count stays at zero until reconfigured
         if (wr_reload && enable_reg && !fault_reg && !wr_cfg)
            load_reg <= 1'b1; // R9 R10 R19
         if (wr_stby)
            standby_reg <= wdata_i[0]; // R12
      end
   end

   // ------------------------------------------------------------
   // tick and counter
   // ------------------------------------------------------------
   swd_prescaler #(
      .DIV       (TICK_CYC)
   ) u_pre (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n),
      .restart_i (wr_cfg),
      .tick_o    (tick)
   );

   swd_downcount #(
      .W          (16)
   ) u_cnt (
      .ref_clk_i  (ref_clk_i),
      .rst_n_i    (rst_n),
      .load_i     (load_reg),
      .load_val_i (start_reg),
      .run_i      (enable_reg),
      .tick_i     (tick),
      .count_o    (count),
      .zero_o     (zero)
   );

   // ------------------------------------------------------------
   // malfunction flag
   // ------------------------------------------------------------
   always @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n)
         fault_reg <= 1'b0;
      else if (cfg_pulse_reg || wr_cfg)
         fault_reg <= 1'b0; // R19
      else if (enable_reg && zero && !load_reg && !fault_reg)
         fault_reg <= 1'b1; // R2 R16
   end

   // ------------------------------------------------------------
   // expiry actions and pin
   // ------------------------------------------------------------
   wire expired = enable_reg && fault_reg;

   always @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         halt_main_o  <= 1'b0;
         halt_cop_o   <= 1'b0;
         force_low_o  <= 1'b0;
         gen_out_en_o <= {N_GEN{1'b1}};
         dio_out_en_o <= {N_DIO{1'b1}};
         wd_out_o     <= 1'b0; // R14
      end else begin
         halt_main_o  <= expired && mode_reg[`SWD_MODE_HALT_MAIN]; // R5
         halt_cop_o   <= expired && mode_reg[`SWD_MODE_HALT_COP]; // R5
         force_low_o  <= expired && mode_reg[`SWD_MODE_FORCE_LOW]; // R6
         gen_out_en_o <= {N_GEN{!(expired && mode_reg[`SWD_MODE_FORCE_LOW])}}; // R6
         dio_out_en_o <= {N_DIO{!(expired && mode_reg[`SWD_MODE_FORCE_LOW])}}; // R6
         if (enable_reg && mode_reg[`SWD_MODE_PIN])
            wd_out_o <= !fault_reg; // R7
         else
            wd_out_o <= standby_reg; // R8 R13
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_o <= 32'h00000000;
      end else if (rd_i) begin
         case (addr_i)
            `SWD_OFS_CONFIG:  rdata_o <= {24'h000000, mode_reg, 3'h0, enable_reg};
            `SWD_OFS_START:   rdata_o <= {16'h0000, start_reg};
            `SWD_OFS_STANDBY: rdata_o <= {31'h00000000, standby_reg};
            `SWD_OFS_STATUS:  rdata_o <= {30'h00000000, fault_reg, enable_reg}; // R15 R16 R17 R18
            `SWD_OFS_COUNT:   rdata_o <= {16'h0000, count};
            default:          rdata_o <= 32'h00000000;
         endcase
      end else begin
         rdata_o <= 32'h00000000;
      end
   end
endmodule

// ===== swd_chk_sva.sv
`timescale 1ns/100ps
`include "swd_regs.vh"
module swd_chk #(
   parameter TICK_CYC = 4,
   parameter N_GEN    = 8,
   parameter N_DIO    = 33
) (
   input wire logic             ref_clk_i,
   input wire logic             reset_n_i,
   input wire logic [3:0]       addr_i,
   input wire logic [31:0]      wdata_i,
   input wire logic             wr_i,
   input wire logic             rd_i,
   input wire logic [31:0]      rdata_o,
   input wire logic             halt_main_o,
   input wire logic             halt_cop_o,
   input wire logic             force_low_o,
   input wire logic [N_GEN-1:0] gen_out_en_o,
   input wire logic [N_DIO-1:0] dio_out_en_o,
   input wire logic             wd_out_o
);
   // ---------------------------
   // shadow of written settings
   // ---------------------------
   logic [3:0] mode_q;
   logic       en_q;
   logic       sb_q;
   wire        cfg_wr = wr_i && addr_i == `SWD_OFS_CONFIG;
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_q <= 4'h0;
         en_q   <= 1'b0;
         sb_q   <= 1'b0;
      end else begin
         if (cfg_wr) begin
            mode_q <= wdata_i[7:4];
            en_q   <= wdata_i[0];
         end
         if (wr_i && addr_i == `SWD_OFS_STANDBY) begin
            sb_q <= wdata_i[0];
         end
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_arm_pin;
      cfg_wr && wdata_i[0] && wdata_i[6];
   endsequence
   sequence s_cfg_idle;
      cfg_wr && !(wdata_i[0] && wdata_i[6]) ##1 !wr_i;
   endsequence
   a_reset_quiet: assert property (disable iff (1'b0)
      !reset_n_i ##1 !reset_n_i |-> !wd_out_o && !halt_main_o) else $error("outputs active in reset");
   a_status_read: assert property (
      $past(rd_i && addr_i == `SWD_OFS_STATUS) |-> rdata_o[31:2] == 30'h0 && rdata_o[0] == $past(en_q))
      else $error("status word");
   a_pin_arm: assert property (s_arm_pin |-> ##2 wd_out_o) else $error("pin not raised");
   a_standby_lvl: assert property (s_cfg_idle |-> ##1 wd_out_o == sb_q) else $error("standby level");
   a_release_acts: assert property (
      cfg_wr && !wdata_i[0] |-> ##2 !(halt_main_o | halt_cop_o | force_low_o)) else $error("actions kept");
   a_expiry_acts: assert property (
      $rose(halt_main_o | halt_cop_o | force_low_o) |-> {force_low_o, halt_cop_o, halt_main_o} ==
      {mode_q[3], mode_q[1:0]} && !(mode_q[2] && wd_out_o)) else $error("expiry actions");
   a_fault_hold: assert property (
      halt_main_o && !cfg_wr && !$past(cfg_wr) |=> halt_main_o) else $error("halt dropped");
   a_force_lines: assert property (
      force_low_o |-> gen_out_en_o == '0 && dio_out_en_o == '0) else $error("lines not forced");
endmodule
bind swd_supervisor swd_chk #(.TICK_CYC(TICK_CYC), .N_GEN(N_GEN), .N_DIO(N_DIO)) chk (.*);

// ===== swd_io_model.sv
`timescale 1ns/100ps
module swd_io_model (
   input  wire logic [7:0] gen_out_en_i,
   input  wire logic       halt_main_i,
   input  wire logic       halt_cop_i,
   output wire logic [7:0] gen_pin_o,
   output wire logic       cpu_run_o
);
   // drivers want every line high; the permit gates them
   assign gen_pin_o = gen_out_en_i;
   assign cpu_run_o = !(halt_main_i | halt_cop_i);
endmodule

// ===== system_watchdog_supervisor_bench.sv
`timescale 1ns/100ps
`include "swd_regs.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; $display("Error %0t: %h vs %h", $time, a, b); end end
module system_watchdog_supervisor_bench;
   localparam int T = 4;
   logic        ref_clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, seen = 1'b0;
   logic [3:0]  addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0, rdata_o, e;
   logic        halt_main_o, halt_cop_o, force_low_o, wd_out_o, cpu_run;
   logic [7:0]  gen_out_en_o, gen_pin;
   logic [32:0] dio_out_en_o;
   logic [31:0] expq[$];
   int          bad_count = 0, checks_done = 0, n, m, s;
   always #20 ref_clk_i = ~ref_clk_i;
   swd_supervisor #(.TICK_CYC(T)) uut (.*);
   swd_io_model drv (.gen_out_en_i(gen_out_en_o), .halt_main_i(halt_main_o), .halt_cop_i(halt_cop_o),
      .gen_pin_o(gen_pin), .cpu_run_o(cpu_run));
   // ------------------
   // read data checker
   // ------------------
   always @(posedge ref_clk_i) begin
      seen <= rd_i;
      if (seen) begin
         e = expq.pop_front();
         `CHK(rdata_o, e)
      end
   end
   task stop_test;
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      if (!w) expq.push_back(d);
      wr_i <= w;
      rd_i <= !w;
      addr_i <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task wexp;
      @(posedge ref_clk_i);
      for (n = 0; n < 300 && (halt_main_o | halt_cop_o | force_low_o | !wd_out_o) !== 1'b1; n++)
         @(posedge ref_clk_i);
      if (n == 300) begin
         bad_count++;
         stop_test();
      end
      `CHK(n >= (s - 1) * T && n <= s * T + 6, 1'b1)
   endtask
   initial begin
      void'($urandom(32'hbe3f));
      repeat (16) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      `CHK(wd_out_o, 1'b0)
      acc(1'b0, `SWD_OFS_STATUS, 32'h0);
      acc(1'b0, 4'hf, 32'h0);
      acc(1'b0, `SWD_OFS_START, 32'hfffe);
      acc(1'b1, `SWD_OFS_START, 32'h0000ffff);
      acc(1'b0, `SWD_OFS_START, 32'h0000fffe);
      acc(1'b1, `SWD_OFS_START, 32'h00000000);
      acc(1'b0, `SWD_OFS_START, 32'h00000001);
      acc(1'b1, `SWD_OFS_RELOAD, 32'h0);
      acc(1'b0, `SWD_OFS_STATUS, 32'h0);
      acc(1'b0, `SWD_OFS_COUNT, 32'h0);
      for (n = 1; n >= 0; n--) begin
         acc(1'b1, `SWD_OFS_STANDBY, n);
         acc(1'b1, `SWD_OFS_CONFIG, 32'h40);
         @(posedge ref_clk_i);
         `CHK(wd_out_o, n[0])
      end
      s = 5;
      acc(1'b1, `SWD_OFS_START, s);
      acc(1'b1, `SWD_OFS_CONFIG, 32'hf1);
      @(posedge ref_clk_i);
      `CHK({wd_out_o, cpu_run}, 2'h3)
      acc(1'b0, `SWD_OFS_STATUS, 32'h1);
      repeat (5) begin
         repeat (8) @(posedge ref_clk_i);
         acc(1'b1, `SWD_OFS_RELOAD, 32'h0);
      end
      `CHK(cpu_run, 1'b1)
      wexp();
      `CHK({force_low_o, wd_out_o, cpu_run, gen_pin}, 11'h400)
      `CHK(dio_out_en_o, 33'h000000000)
      acc(1'b1, `SWD_OFS_STANDBY, 32'h1);
      for (m = 0; m < 4; m++) begin
         s = $urandom_range(3, 1);
         acc(1'b1, `SWD_OFS_START, s);
         acc(1'b1, `SWD_OFS_CONFIG, (32'h10 << m) | 32'h1);
         wexp();
         `CHK({force_low_o, !wd_out_o, halt_cop_o, halt_main_o}, 4'h1 << m)
         `CHK(cpu_run, m > 1)
         acc(1'b0, `SWD_OFS_STATUS, 32'h3);
         `CHK(dio_out_en_o == 33'h000000000, m == 3)
         acc(1'b1, `SWD_OFS_RELOAD, 32'h0);
         acc(1'b0, `SWD_OFS_COUNT, 32'h0);
      end
      acc(1'b1, `SWD_OFS_CONFIG, 32'h0);
      @(posedge ref_clk_i);
      `CHK({force_low_o, gen_pin}, 9'h0ff)
      `CHK(&dio_out_en_o, 1'b1)
      acc(1'b0, `SWD_OFS_STATUS, 32'h0);
      stop_test();
   end
endmodule
